// [imb_pkg.sv]
/*
 * Constants and types of the mode and bus-control block.
 * Assumes one clock; bus clock is a sampled input.
 */
package imb_pkg;

	// ************************************************************
	// control register 0 fields
	// ************************************************************
	localparam int          CTL_BTC_DIS_BIT   = 30;
	localparam int          CTL_FETCH_COH_BIT = 23;
	localparam int          CTL_NO_DRETRY_BIT = 8;
	localparam int          CTL_NO_PRECH_BIT  = 7;
	localparam logic [31:0] CTL_RESET         = 32'h0;

	// ************************************************************
	// config register 1: read-only clock ratio field
	// ************************************************************
	localparam int          CFG_RATIO_LSB = 28;
	localparam int          CFG_RATIO_W   = 4;
	localparam logic [27:0] CFG_LOW_ZERO  = 28'h0;

	localparam logic [3:0] RATIO_1_1 = 4'h0;
	localparam logic [3:0] RATIO_3_2 = 4'h1;
	localparam logic [3:0] RATIO_2_1 = 4'h2;
	localparam logic [3:0] RATIO_5_2 = 4'h3;
	localparam logic [3:0] RATIO_3_1 = 4'h4;
	localparam logic [3:0] RATIO_4_1 = 4'h5;

	// precharge width in processor cycles, about half a bus cycle
	localparam logic [1:0] PRECH_SHORT = 2'h1;
	localparam logic [1:0] PRECH_LONG  = 2'h2;

	// ************************************************************
	// open-drain bus signals that receive precharge
	// ************************************************************
	localparam int PIN_ADDR_BUSY  = 0;
	localparam int PIN_DATA_BUSY  = 1;
	localparam int PIN_ADDR_RETRY = 2;
	localparam int PIN_SHARED     = 3;
	localparam int NUM_PRECH      = 4;

	// synchronised active-low inputs
	localparam int SYN_TA     = 4;
	localparam int SYN_DRETRY = 5;
	localparam int SYN_DGRANT = 6;
	localparam int NUM_SYN    = 7;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		CB_CASTOUT = 2'h0,
		CB_FLUSH   = 2'h1,
		CB_CLEAN   = 2'h2
	} imb_cb_kind_t;

	typedef enum logic [2:0] {
		LS_IDLE   = 3'h1,
		LS_FIRST  = 3'h2,
		LS_SECOND = 3'h4
	} imb_ls_state_t;

	function automatic logic [1:0] imb_prech_len(input logic [3:0] ratio);
		if (ratio == RATIO_5_2 || ratio == RATIO_3_1 || ratio == RATIO_4_1) begin
			return PRECH_LONG;
		end
		return PRECH_SHORT;
	endfunction : imb_prech_len

endpackage : imb_pkg

// [imb_cb_if.sv]
/*
 * Top to copyback store carrier.
 * Assumes one clock at both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface imb_cb_if import imb_pkg::*; #(parameter int AW = 32);
	logic         push_valid;
	logic         push_ready;
	logic [AW-1:0] push_addr;
	imb_cb_kind_t push_kind;
	logic         pop_valid;
	logic         pop_ready;
	logic [AW-1:0] pop_addr;
	imb_cb_kind_t pop_kind;

	modport src (output push_valid, push_addr, push_kind, pop_ready,
	             input  push_ready, pop_valid, pop_addr, pop_kind);
	modport store (input  push_valid, push_addr, push_kind, pop_ready,
	               output push_ready, pop_valid, pop_addr, pop_kind);
endinterface : imb_cb_if
`default_nettype wire

// [imb_copyback.sv]
/*
 * Copyback buffers, drained in order.
 * Assumes the drain may stall at will.
 */
`timescale 1ns/1ps
`default_nettype none
module imb_copyback import imb_pkg::*; #(
	parameter int DEPTH = 3,
	parameter int AW    = 32
) (
	input  wire logic i_clk,
	input  wire logic i_reset,
	imb_cb_if.store   cb
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [PW:0]   FULL = (PW + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][AW-1:0] addr;
		logic [DEPTH-1:0][1:0]    kind;
		logic [PW-1:0]            wr;
		logic [PW-1:0]            rd;
		logic [PW:0]              cnt;
		logic                     ready;
		logic                     valid;
	} imb_cb_st_t;

	imb_cb_st_t st_ff;
	imb_cb_st_t nxt_st;
	logic       push;
	logic       pop;

	assign cb.push_ready = st_ff.ready;
	assign cb.pop_valid  = st_ff.valid;
	assign cb.pop_addr   = st_ff.addr[st_ff.rd];
	assign cb.pop_kind   = imb_cb_kind_t'(st_ff.kind[st_ff.rd]);

	always_comb begin
		nxt_st = st_ff;
		push   = cb.push_valid && st_ff.ready;
		pop    = cb.pop_ready && st_ff.valid;
		if (push) begin
			nxt_st.addr[st_ff.wr] = cb.push_addr;
			nxt_st.kind[st_ff.wr] = cb.push_kind;
			nxt_st.wr = (st_ff.wr == LAST) ? '0 : st_ff.wr + 1'b1;
		end
		if (pop) begin
			nxt_st.rd = (st_ff.rd == LAST) ? '0 : st_ff.rd + 1'b1;
		end
		if (push && !pop) begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end else if (pop && !push) begin
			nxt_st.cnt = st_ff.cnt - 1'b1;
		end
		nxt_st.ready = (nxt_st.cnt != FULL);
		nxt_st.valid = (nxt_st.cnt != '0);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_ff       <= '0;
			st_ff.ready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule : imb_copyback
`default_nettype wire

// [imb_top.sv]
/*
 * Control/config registers, target cache,
 * snoop flag, precharge, read qualification,
 * access split and copyback buffers.
 * Assumes bus clock, pins and strap are
 * asynchronous; all else on i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module imb_top import imb_pkg::*; #(
	parameter int BTC_N    = 64,
	parameter int CB_DEPTH = 3
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_reset,
	input  wire logic [3:0]           i_ratio_strap,
	input  wire logic                 i_ctl_wr,
	input  wire logic [31:0]          i_ctl_wdata,
	output logic [31:0]               o_impl_control_reg0,
	output logic [31:0]               o_impl_config_reg1,
	input  wire logic                 i_bt_lookup,
	input  wire logic [29:0]          i_bt_pc,
	input  wire logic                 i_bt_alloc,
	input  wire logic [29:0]          i_bt_alloc_pc,
	input  wire logic [29:0]          i_bt_alloc_tgt,
	output logic                      o_bt_hit,
	output logic [29:0]               o_bt_target,
	input  wire logic                 i_fetch_start,
	input  wire logic                 i_fetch_coherent,
	input  wire logic                 i_instr_translate_enable,
	output logic                      o_global_snoop_flag_n,
	input  wire logic [NUM_PRECH-1:0] i_sig_drive,
	input  wire logic [NUM_PRECH-1:0] i_sig_pin,
	output logic [NUM_PRECH-1:0]      o_sig_out,
	output logic [NUM_PRECH-1:0]      o_sig_oe,
	output logic [NUM_PRECH-1:0]      o_sig_seen_n,
	input  wire logic                 i_bus_clk,
	input  wire logic                 i_data_grant_n,
	input  wire logic                 i_data_retry_sig_n,
	input  wire logic                 i_transfer_ack_n,
	input  wire logic [63:0]          i_rd_data,
	output logic                      o_qual_data_grant,
	output logic                      o_rd_valid,
	output logic [63:0]               o_rd_data,
	input  wire logic                 i_ls_req,
	input  wire logic [31:0]          i_ls_addr,
	input  wire logic [3:0]           i_ls_size,
	input  wire logic                 i_ls_little,
	output logic                      o_ls_busy,
	output logic                      o_ls_done,
	output logic                      o_align_exc,
	output logic                      o_bus_req,
	output logic [31:0]               o_bus_addr,
	output logic [3:0]                o_bus_size,
	input  wire logic                 i_bus_ack,
	input  wire logic                 i_cb_push,
	input  wire logic [31:0]          i_cb_addr,
	input  wire imb_cb_kind_t         i_cb_kind,
	output logic                      o_cb_ready,
	output logic                      o_cbw_valid,
	output logic [31:0]               o_cbw_addr,
	output var imb_cb_kind_t          o_cbw_kind,
	input  wire logic                 i_cbw_ack
);
	localparam int BTC_IW = $clog2(BTC_N);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [31:0]                   ctl;
		logic [3:0]                    strap_s1;
		logic [3:0]                    strap_s2;
		logic [3:0]                    ratio;
		logic [1:0]                    ratio_wait;
		logic [BTC_N-1:0]              bt_valid;
		logic [BTC_N-1:0][29:0]        bt_tag;
		logic [BTC_N-1:0][29:0]        bt_tgt;
		logic [BTC_IW-1:0]             bt_next;
		logic                          bt_hit;
		logic [29:0]                   bt_out;
		logic                          gbl_n;
		logic                          bclk_s1;
		logic                          bclk_s2;
		logic                          bclk_d;
		logic [NUM_SYN-1:0]            syn_s1;
		logic [NUM_SYN-1:0]            syn_s2;
		logic [63:0]                   dat_s1;
		logic [63:0]                   dat_s2;
		logic                          rd_pend;
		logic [63:0]                   rd_pend_dat;
		logic                          rd_valid;
		logic [63:0]                   rd_dat;
		logic                          qual_grant;
		logic [NUM_PRECH-1:0]          drv_d;
		logic [NUM_PRECH-1:0][1:0]     prech_cnt;
		logic [NUM_PRECH-1:0]          pin_out;
		logic [NUM_PRECH-1:0]          pin_oe;
		imb_ls_state_t                 ls;
		logic [31:0]                   ls_addr2;
		logic [3:0]                    ls_size2;
		logic                          bus_req;
		logic [31:0]                   bus_addr;
		logic [3:0]                    bus_size;
		logic                          align_exc;
		logic                          ls_done;
	} imb_st_t;

	imb_st_t     st_ff;
	imb_st_t     nxt_st;
	logic        bus_edge;
	logic        no_dretry;
	logic        prech_off;
	logic [4:0]  dw_end;
	logic [4:0]  w_end;
	logic [3:0]  first_size;

	imb_cb_if #(.AW(32)) cb ();

	imb_copyback #(.DEPTH(CB_DEPTH), .AW(32)) u_copyback (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.cb      (cb)
	);

	assign cb.push_valid = i_cb_push;
	assign cb.push_addr  = i_cb_addr;
	assign cb.push_kind  = i_cb_kind;
	assign cb.pop_ready  = i_cbw_ack;
	assign o_cb_ready    = cb.push_ready;
	assign o_cbw_valid   = cb.pop_valid;
	assign o_cbw_addr    = cb.pop_addr;
	assign o_cbw_kind    = cb.pop_kind;

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_impl_control_reg0   = st_ff.ctl;
	// ratio field has no write path
	assign o_impl_config_reg1    = {st_ff.ratio, CFG_LOW_ZERO};
	assign o_bt_hit              = st_ff.bt_hit;
	assign o_bt_target           = st_ff.bt_out;
	assign o_global_snoop_flag_n = st_ff.gbl_n;
	assign o_sig_out             = st_ff.pin_out;
	assign o_sig_oe              = st_ff.pin_oe;
	assign o_sig_seen_n          = st_ff.syn_s2[NUM_PRECH-1:0];
	assign o_qual_data_grant     = st_ff.qual_grant;
	assign o_rd_valid            = st_ff.rd_valid;
	assign o_rd_data             = st_ff.rd_dat;
	assign o_ls_busy             = !st_ff.ls[0];
	assign o_ls_done             = st_ff.ls_done;
	assign o_align_exc           = st_ff.align_exc;
	assign o_bus_req             = st_ff.bus_req;
	assign o_bus_addr            = st_ff.bus_addr;
	assign o_bus_size            = st_ff.bus_size;

	always_comb begin
		nxt_st     = st_ff;
		bus_edge   = st_ff.bclk_s2 && !st_ff.bclk_d;
		no_dretry  = st_ff.ctl[CTL_NO_DRETRY_BIT];
		prech_off  = st_ff.ctl[CTL_NO_PRECH_BIT];
		dw_end     = {2'h0, i_ls_addr[2:0]} + {1'h0, i_ls_size};
		w_end      = {3'h0, i_ls_addr[1:0]} + {1'h0, i_ls_size};
		first_size = 4'h4 - {2'h0, i_ls_addr[1:0]};

		// ************************************************************
		// control register and ratio strap
		// ************************************************************
		// write lands, read echoes
		if (i_ctl_wr) begin
			nxt_st.ctl = i_ctl_wdata;
		end
		nxt_st.strap_s1 = i_ratio_strap;
		nxt_st.strap_s2 = st_ff.strap_s1;
		// strap caught once past both flops
		if (st_ff.ratio_wait != 2'h3) begin
			nxt_st.ratio_wait = st_ff.ratio_wait + 2'h1;
		end
		if (st_ff.ratio_wait == 2'h2) nxt_st.ratio = st_ff.strap_s2;

		// ************************************************************
		// branch target cache
		// ************************************************************
		nxt_st.bt_hit = 1'b0;
		nxt_st.bt_out = '0;
		if (st_ff.ctl[CTL_BTC_DIS_BIT]) begin
			nxt_st.bt_valid = '0;
		end else begin
			if (i_bt_lookup) begin
				for (int i = 0; i < BTC_N; i++) begin
					if (st_ff.bt_valid[i] && st_ff.bt_tag[i] == i_bt_pc) begin
						nxt_st.bt_hit = 1'b1;
						nxt_st.bt_out = st_ff.bt_tgt[i];
					end
				end
			end
			if (i_bt_alloc) begin
				nxt_st.bt_valid[st_ff.bt_next] = 1'b1;
				nxt_st.bt_tag[st_ff.bt_next]   = i_bt_alloc_pc;
				nxt_st.bt_tgt[st_ff.bt_next]   = i_bt_alloc_tgt;
				nxt_st.bt_next                 = st_ff.bt_next + 1'b1;
			end
		end

		// ************************************************************
		// instruction fetch snoop flag
		// ************************************************************
		// coherency bit gates the flag
		nxt_st.gbl_n = 1'b1;
		if (i_fetch_start && st_ff.ctl[CTL_FETCH_COH_BIT]) begin
			nxt_st.gbl_n = i_instr_translate_enable ? !i_fetch_coherent : 1'b0;
		end

		// ************************************************************
		// precharge of open-drain bus signals
		// ************************************************************
		nxt_st.drv_d = i_sig_drive;
		for (int i = 0; i < NUM_PRECH; i++) begin
			if (i_sig_drive[i]) begin
				nxt_st.prech_cnt[i] = '0;
			end else if (st_ff.drv_d[i]) begin
				nxt_st.prech_cnt[i] = imb_prech_len(st_ff.ratio);
				if (prech_off && (i == PIN_ADDR_RETRY || i == PIN_SHARED)) begin
					nxt_st.prech_cnt[i] = '0;
				end
			end else if (st_ff.prech_cnt[i] != '0) begin
				nxt_st.prech_cnt[i] = st_ff.prech_cnt[i] - 1'b1;
			end
			nxt_st.pin_out[i] = !i_sig_drive[i];
			nxt_st.pin_oe[i]  = i_sig_drive[i] || (nxt_st.prech_cnt[i] != '0);
		end

		// ************************************************************
		// bus clock sampling and read data path
		// ************************************************************
		// two-flop sync
		nxt_st.bclk_s1 = i_bus_clk;
		nxt_st.bclk_s2 = st_ff.bclk_s1;
		nxt_st.bclk_d  = st_ff.bclk_s2;
		nxt_st.syn_s1  = {i_data_grant_n, i_data_retry_sig_n, i_transfer_ack_n, i_sig_pin};
		nxt_st.syn_s2  = st_ff.syn_s1;
		nxt_st.dat_s1  = i_rd_data;
		nxt_st.dat_s2  = st_ff.dat_s1;
		nxt_st.rd_valid = 1'b0;
		if (bus_edge) begin
			nxt_st.qual_grant = !st_ff.syn_s2[SYN_DGRANT] && st_ff.syn_s2[PIN_DATA_BUSY] &&
			                    (no_dretry || st_ff.syn_s2[SYN_DRETRY]);
			if (no_dretry) begin
				// hand data over at the ack edge
				nxt_st.rd_pend = 1'b0;
				if (!st_ff.syn_s2[SYN_TA]) begin
					nxt_st.rd_valid = 1'b1;
					nxt_st.rd_dat   = st_ff.dat_s2;
				end
			end else begin
				// hold data one bus cycle for retry
				if (st_ff.rd_pend && st_ff.syn_s2[SYN_DRETRY]) begin
					nxt_st.rd_valid = 1'b1;
					nxt_st.rd_dat   = st_ff.rd_pend_dat;
				end
				nxt_st.rd_pend     = !st_ff.syn_s2[SYN_TA];
				nxt_st.rd_pend_dat = st_ff.dat_s2;
			end
		end

		// ************************************************************
		// load/store access splitting
		// ************************************************************
		nxt_st.align_exc = 1'b0;
		nxt_st.ls_done   = 1'b0;
		case (st_ff.ls)
			LS_IDLE: begin
				if (i_ls_req) begin
					// same fault test for both orders
					if (dw_end > 5'h08) begin
						nxt_st.align_exc = 1'b1;
					end else if (i_ls_little && w_end > 5'h04) begin
						nxt_st.bus_req  = 1'b1;
						nxt_st.bus_addr = i_ls_addr;
						nxt_st.bus_size = first_size;
						nxt_st.ls_size2 = i_ls_size - first_size;
						nxt_st.ls_addr2 = {i_ls_addr[31:2] + 30'h1, 2'h0};
						nxt_st.ls       = LS_FIRST;
					end else begin
						nxt_st.bus_req  = 1'b1;
						nxt_st.bus_addr = i_ls_addr;
						nxt_st.bus_size = i_ls_size;
						nxt_st.ls       = LS_SECOND;
					end
				end
			end
			LS_FIRST: begin
				if (i_bus_ack) begin
					nxt_st.bus_addr = st_ff.ls_addr2;
					nxt_st.bus_size = st_ff.ls_size2;
					nxt_st.ls       = LS_SECOND;
				end
			end
			LS_SECOND: begin
				if (i_bus_ack) begin
					nxt_st.bus_req = 1'b0;
					nxt_st.ls_done = 1'b1;
					nxt_st.ls      = LS_IDLE;
				end
			end
			default: begin
				nxt_st.bus_req = 1'b0;
				nxt_st.ls      = LS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_ff         <= '0;
			st_ff.ctl     <= CTL_RESET;
			st_ff.gbl_n   <= 1'b1;
			st_ff.syn_s1  <= '1;
			st_ff.syn_s2  <= '1;
			st_ff.ls      <= LS_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule : imb_top
`default_nettype wire

// [imb_top_chk.sv]
/*
 * Port checker bound into imb_top.
 * Assumes one clock, synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module imb_top_chk import imb_pkg::*; (
	input wire logic                 i_clk,
	input wire logic                 i_reset,
	input wire logic                 i_ctl_wr,
	input wire logic [31:0]          i_ctl_wdata,
	input wire logic [31:0]          o_impl_control_reg0,
	input wire logic [31:0]          o_impl_config_reg1,
	input wire logic                 i_bt_lookup,
	input wire logic                 o_bt_hit,
	input wire logic                 i_fetch_start,
	input wire logic                 i_fetch_coherent,
	input wire logic                 i_instr_translate_enable,
	input wire logic                 o_global_snoop_flag_n,
	input wire logic [NUM_PRECH-1:0] i_sig_drive,
	input wire logic [NUM_PRECH-1:0] o_sig_out,
	input wire logic [NUM_PRECH-1:0] o_sig_oe,
	input wire logic                 i_ls_req,
	input wire logic [31:0]          i_ls_addr,
	input wire logic [3:0]           i_ls_size,
	input wire logic                 i_ls_little,
	input wire logic                 o_ls_busy,
	input wire logic                 o_align_exc,
	input wire logic                 o_bus_req,
	input wire logic [31:0]          o_bus_addr,
	input wire logic                 o_cb_ready,
	input wire logic                 o_cbw_valid
);
	logic ls_take;
	logic ls_fault;
	logic ls_split;
	assign ls_take  = i_ls_req && !o_ls_busy;
	assign ls_fault = {2'h0, i_ls_addr[2:0]} + {1'h0, i_ls_size} > 5'h08;
	assign ls_split = i_ls_little && {3'h0, i_ls_addr[1:0]} + {1'h0, i_ls_size} > 5'h04;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);

	a_ctl_echo: assert property (i_ctl_wr |=> o_impl_control_reg0 == $past(i_ctl_wdata))
		else $error("reg 0 write lost");
	a_cfg_read_only: assert property (i_ctl_wr |=> $stable(o_impl_config_reg1) &&
		o_impl_config_reg1[27:0] == CFG_LOW_ZERO) else $error("reg 1 changed");
	a_btc_dis_miss: assert property (i_bt_lookup && o_impl_control_reg0[CTL_BTC_DIS_BIT] |=> !o_bt_hit)
		else $error("hit while disabled");
	a_snoop_off: assert property (i_fetch_start && !o_impl_control_reg0[CTL_FETCH_COH_BIT]
		|=> o_global_snoop_flag_n) else $error("flag with bit clear");
	a_snoop_idle: assert property (!i_fetch_start |=> o_global_snoop_flag_n)
		else $error("flag without fetch");
	a_snoop_page: assert property (i_fetch_start && o_impl_control_reg0[CTL_FETCH_COH_BIT] &&
		i_instr_translate_enable |=> o_global_snoop_flag_n == !$past(i_fetch_coherent))
		else $error("flag not page attr");
	a_snoop_real: assert property (i_fetch_start && o_impl_control_reg0[CTL_FETCH_COH_BIT] &&
		!i_instr_translate_enable |=> !o_global_snoop_flag_n) else $error("no flag untranslated");
	a_prech_pulse: assert property ($fell(i_sig_drive[PIN_ADDR_BUSY]) |=>
		o_sig_out[PIN_ADDR_BUSY] && o_sig_oe[PIN_ADDR_BUSY]) else $error("no precharge");
	a_prech_drive: assert property (i_sig_drive[PIN_DATA_BUSY] |=>
		!o_sig_out[PIN_DATA_BUSY] && o_sig_oe[PIN_DATA_BUSY]) else $error("pin not driven low");
	a_prech_off: assert property (o_impl_control_reg0[CTL_NO_PRECH_BIT] && $fell(i_sig_drive[PIN_SHARED])
		|=> !o_sig_oe[PIN_SHARED]) else $error("shared precharged");
	a_ls_fault: assert property (ls_take && ls_fault |=> o_align_exc && !o_bus_req)
		else $error("no fault");
	a_ls_low_first: assert property (ls_take && ls_split && !ls_fault |=> o_bus_req &&
		o_bus_addr == $past(i_ls_addr)) else $error("split not low first");
	a_cb_full: assert property (!o_cb_ready |-> o_cbw_valid)
		else $error("full while empty");
endmodule : imb_top_chk

bind imb_top imb_top_chk chk_u (.*);
`default_nettype wire

// [imb_bus_model.sv]
/*
 * Far side: bus clock, acks, drain, pull-ups, read beats.
 * Assumes the bench sets stall and ack delay.
 */
`timescale 1ns/1ps
`default_nettype none
module imb_bus_model import imb_pkg::*; (
	input  wire logic                 i_clk,
	input  wire logic                 i_stall,
	input  wire logic [3:0]           i_ack_wait,
	input  wire logic                 i_bus_req,
	input  wire logic                 i_cbw_valid,
	input  wire logic [NUM_PRECH-1:0] i_sig_out,
	input  wire logic [NUM_PRECH-1:0] i_sig_oe,
	output logic                      o_bus_clk,
	output logic                      o_bus_ack,
	output logic                      o_cbw_ack,
	output logic [NUM_PRECH-1:0]      o_sig_pin,
	output logic                      o_ta_n,
	output logic [63:0]               o_rd_data
);
	logic [3:0] wait_ff;

	// phase offset keeps bus edges off i_clk edges
	initial begin
		o_bus_clk = 1'h0;
		o_bus_ack = 1'h0;
		wait_ff   = 4'h0;
		o_ta_n    = 1'h1;
		o_rd_data = 64'h0;
		#3;
		forever #40 o_bus_clk = ~o_bus_clk;
	end

	// pull-ups on every pin
	assign o_sig_pin = ~(i_sig_oe & ~i_sig_out);
	assign o_cbw_ack = i_cbw_valid && !i_stall;

	always @(posedge i_clk) begin
		o_bus_ack <= i_bus_req && !o_bus_ack && wait_ff >= i_ack_wait;
		wait_ff   <= (i_bus_req && !o_bus_ack) ? wait_ff + 4'h1 : 4'h0;
	end

	// one beat; data inverted after hold
	task automatic beat(input logic [63:0] d);
		@(posedge o_bus_clk);
		o_ta_n    <= 1'h0;
		o_rd_data <= d;
		@(posedge o_bus_clk);
		o_ta_n    <= 1'h1;
		o_rd_data <= ~d;
	endtask : beat
endmodule : imb_bus_model
`default_nettype wire

// [imb_top_tb_top.sv]
/*
 * Self-checking bench for imb_top.
 * Assumes the package constants.
 */
`timescale 1ns/1ps
`default_nettype none
module imb_top_tb_top import imb_pkg::*;;
	logic i_clk, i_reset, i_ctl_wr, i_bt_lookup, i_bt_alloc, i_fetch_start, i_fetch_coherent, stall;
	logic i_instr_translate_enable, i_bus_clk, i_data_grant_n, i_data_retry_sig_n, i_transfer_ack_n;
	logic i_ls_req, i_ls_little, i_bus_ack, i_cb_push, i_cbw_ack, o_bt_hit, o_global_snoop_flag_n;
	logic o_qual_data_grant, o_rd_valid, o_ls_busy, o_ls_done, o_align_exc, o_bus_req, o_cb_ready, o_cbw_valid;
	logic [3:0]   i_ratio_strap, i_sig_drive, i_sig_pin, i_ls_size, o_sig_out, o_sig_oe, o_sig_seen_n, o_bus_size;
	logic [3:0]   ack_wait;
	logic [29:0]  i_bt_pc, i_bt_alloc_pc, i_bt_alloc_tgt, o_bt_target;
	logic [31:0]  i_ctl_wdata, o_impl_control_reg0, o_impl_config_reg1, i_ls_addr, o_bus_addr, i_cb_addr, o_cbw_addr;
	logic [63:0]  i_rd_data, o_rd_data;
	imb_cb_kind_t i_cb_kind, o_cbw_kind;
	logic [36:0]  cs [5];
	int           fails, num_checks, k, p;
	time          lat [2], t0;

	imb_top dut_u (.*);
	imb_bus_model bus_u (.i_clk(i_clk), .i_stall(stall), .i_ack_wait(ack_wait), .i_bus_req(o_bus_req),
		.i_cbw_valid(o_cbw_valid), .i_sig_out(o_sig_out), .i_sig_oe(o_sig_oe), .o_bus_clk(i_bus_clk),
		.o_bus_ack(i_bus_ack), .o_cbw_ack(i_cbw_ack), .o_sig_pin(i_sig_pin), .o_ta_n(i_transfer_ack_n),
		.o_rd_data(i_rd_data));

	// ********
	// tasks
	// ********
	task automatic tick(input int n = 1);
		repeat (n) @(posedge i_clk);
	endtask : tick

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_of_test;
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [31:0] d);
		i_ctl_wr    <= 1'h1;
		i_ctl_wdata <= d;
		tick();
		i_ctl_wr <= 1'h0;
		tick();
	endtask : wr

	task automatic alloc(input logic [29:0] pc, input logic [29:0] tgt);
		i_bt_alloc     <= 1'h1;
		i_bt_alloc_pc  <= pc;
		i_bt_alloc_tgt <= tgt;
		tick();
		i_bt_alloc <= 1'h0;
	endtask : alloc

	task automatic look(input logic [29:0] pc, input logic hit, input logic [29:0] tgt);
		i_bt_lookup <= 1'h1;
		i_bt_pc     <= pc;
		tick();
		i_bt_lookup <= 1'h0;
		tick();
		chk({o_bt_hit, o_bt_target}, {hit, tgt});
	endtask : look

	// acked accesses against the split rule
	task automatic ls(input logic le, input logic [31:0] a, input logic [3:0] s);
		logic [31:0] ad [$];
		logic [31:0] ea [$];
		logic [3:0]  sz [$];
		logic [3:0]  es [$];
		logic        exc;
		logic [3:0]  s1;
		exc = 1'h0;
		s1  = (le && a[1:0] + s > 4) ? 4'h4 - a[1:0] : s;
		if (a[2:0] + s <= 8) begin
			ea.push_back(a);
			es.push_back(s1);
			if (s1 != s) begin
				ea.push_back({a[31:2], 2'h0} + 32'h0000_0004);
				es.push_back(s - s1);
			end
		end
		i_ls_req    <= 1'h1;
		i_ls_addr   <= a;
		i_ls_size   <= s;
		i_ls_little <= le;
		tick();
		i_ls_req <= 1'h0;
		for (int n = 0; n < 40 && !exc && o_ls_done !== 1'h1; n++) begin
			tick();
			exc = o_align_exc === 1'h1;
			if (o_bus_req === 1'h1 && i_bus_ack === 1'h1) begin
				ad.push_back(o_bus_addr);
				sz.push_back(o_bus_size);
			end
		end
		chk({exc, 8'(ad.size())}, {ea.size() == 0, 8'(ea.size())});
		foreach (ea[i]) if (i < ad.size()) chk({ad[i], sz[i]}, {ea[i], es[i]});
	endtask : ls

	// ********
	// clock, watchdog, sequence
	// ********
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end

	// whole sequence needs about 300 cycles
	initial begin
		#60_000;
		fails++;
		end_of_test();
	end

	initial begin
		i_reset = 1'h1;
		{i_ctl_wr, i_bt_lookup, i_bt_alloc, i_fetch_start, i_fetch_coherent, i_instr_translate_enable} = '0;
		{i_ls_req, i_ls_little, i_cb_push, stall, i_ctl_wdata, i_bt_pc, i_bt_alloc_pc} = '0;
		{i_bt_alloc_tgt, i_sig_drive, i_ls_addr, i_ls_size, i_cb_addr, ack_wait} = '0;
		{i_data_grant_n, i_data_retry_sig_n} = 2'h3;
		i_cb_kind     = CB_CASTOUT;
		i_ratio_strap = RATIO_4_1;
		cs = '{{1'h0, 32'h2, 4'h4}, {1'h1, 32'h2, 4'h4}, {1'h1, 32'h6, 4'h4}, {1'h0, 32'h6, 4'h4},
			{1'h1, 32'h1003, 4'h2}};
		tick(2);
		i_reset <= 1'h0;
		tick(5);
		chk(o_impl_control_reg0, 32'h0);
		chk(o_impl_config_reg1, {RATIO_4_1, CFG_LOW_ZERO});
		wr(32'hffff_ffff);
		chk(o_impl_control_reg0, 32'hffff_ffff);
		chk(o_impl_config_reg1, {RATIO_4_1, CFG_LOW_ZERO});
		wr(32'h0);
		alloc(30'h100, 30'habc);
		look(30'h100, 1'h1, 30'habc);
		wr(32'h1 << CTL_BTC_DIS_BIT);
		look(30'h100, 1'h0, 30'h0);
		alloc(30'h200, 30'hdef);
		look(30'h200, 1'h0, 30'h0);
		wr(32'h0);
		look(30'h100, 1'h0, 30'h0);
		look(30'h200, 1'h0, 30'h0);
		alloc(30'h200, 30'hdef);
		look(30'h200, 1'h1, 30'hdef);
		for (int b = 0; b < 8; b++) begin
			wr(32'(b[2]) << CTL_FETCH_COH_BIT);
			i_instr_translate_enable <= b[1];
			i_fetch_coherent         <= b[0];
			i_fetch_start            <= 1'h1;
			tick();
			i_fetch_start <= 1'h0;
			tick();
			chk(o_global_snoop_flag_n, !(b[2] && (!b[1] || b[0])));
		end
		// last two passes: no retry/shared precharge
		for (k = 0; k < 6; k++) begin
			p = k < 4 ? k : k - 2;
			wr(32'(k >= 4) << CTL_NO_PRECH_BIT);
			i_sig_drive[p] <= 1'h1;
			tick();
			i_sig_drive[p] <= 1'h0;
			tick();
			chk({o_sig_out[p], o_sig_oe[p], i_sig_pin[p]}, 3'h2);
			for (int j = 0; j < PRECH_LONG; j++) begin
				tick();
				chk({o_sig_oe[p], o_sig_out[p] | k >= 4}, {k < 4 || p < PIN_ADDR_RETRY, 1'h1});
				chk(o_sig_seen_n[p], j == 0);
			end
			tick();
			chk(o_sig_oe[p], 1'h0);
		end
		for (int m = 0; m < 2; m++) begin
			wr(32'(m) << CTL_NO_DRETRY_BIT);
			i_data_grant_n     <= 1'h0;
			i_data_retry_sig_n <= 1'h0;
			tick(24);
			chk(o_qual_data_grant, m);
			i_data_retry_sig_n <= 1'h1;
			tick(24);
			fork
				bus_u.beat({32'h89ab_cdef, 32'(m)});
			join_none
			@(posedge i_bus_clk);
			t0 = $time;
			for (int n = 0; n < 60 && o_rd_valid !== 1'h1; n++) tick();
			lat[m] = $time - t0;
			chk(o_rd_data, {32'h89ab_cdef, 32'(m)});
			i_data_grant_n <= 1'h1;
		end
		chk(lat[0] - lat[1], 64'h50);
		wr(32'h0);
		for (int c = 0; c < 5; c++) begin
			ack_wait <= 4'(c);
			ls(cs[c][36], cs[c][35:4], cs[c][3:0]);
			tick();
		end
		// drain stalled: fourth push refused
		stall <= 1'h1;
		for (k = 0; k < 4; k++) begin
			i_cb_push <= 1'h1;
			i_cb_addr <= 32'h1000 + 32'(k);
			i_cb_kind <= imb_cb_kind_t'(k % 3);
			tick();
		end
		i_cb_push <= 1'h0;
		tick();
		chk(o_cb_ready, 1'h0);
		stall <= 1'h0;
		k = 0;
		for (int n = 0; n < 20; n++) begin
			tick();
			if (o_cbw_valid === 1'h1 && i_cbw_ack === 1'h1) begin
				chk({o_cbw_addr, o_cbw_kind}, {32'h1000 + 32'(k), 2'(k)});
				k++;
			end
		end
		chk(k, 3);
		end_of_test();
	end
endmodule : imb_top_tb_top
`default_nettype wire
